// ### ctip_contacts.sv
// Model of the outside contact equipment and the field pulse source.
// Assumes a 64-cycle field; closures change only in mid-field.
`timescale 1ns/1ps
`default_nettype none
module ctip_contacts (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] close_i,
  output logic      [31:0] contact_input_n_o,
  output logic             field_sync_o
);
  logic [5:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q             <= 6'h00;
      field_sync_o      <= 1'b0;
      contact_input_n_o <= 32'hffff_ffff;
    end else begin
      cnt_q        <= cnt_q + 6'h01;
      field_sync_o <= cnt_q < 6'h04;
      // A closed contact pulls its pin to the return; it is held a whole field.
      if (cnt_q == 6'h20) begin
        contact_input_n_o <= ~close_i;
      end
    end
  end
endmodule
`default_nettype wire

// ### ctip_func_mem.sv
// Function assignment memory: one write port and two registered read ports.
// Assumes all ports share one clock; read data appear one edge after the address.
`timescale 1ns/1ps
`default_nettype none
module ctip_func_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8,
  parameter int AW    = 5
) (
  input  wire logic             clk_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_a_i,
  output logic      [WIDTH-1:0] rdata_a_o,
  input  wire logic [AW-1:0]    raddr_b_i,
  output logic      [WIDTH-1:0] rdata_b_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_a_o <= mem_q[raddr_a_i];
    rdata_b_o <= mem_q[raddr_b_i];
  end

endmodule
`default_nettype wire

// ### ctip_pkg.sv
// Constants, register map and carrier types of the contact input and tally port.
// Assumes a 10 MHz system clock and a classic Wishbone register bus.
package ctip_pkg;

  localparam int CTIP_GRP_MAX       = 4;
  localparam int CTIP_GRP_SMALL     = 2;
  localparam int CTIP_IN_PER_GRP    = 8;
  localparam int CTIP_TALLY_PER_GRP = 24;
  localparam int CTIP_OUT_PER_GRP   = 8;
  localparam int CTIP_BANK_SIZE     = 4;
  localparam int CTIP_IN_W          = CTIP_GRP_MAX * CTIP_IN_PER_GRP;
  localparam int CTIP_TALLY_W       = CTIP_GRP_MAX * CTIP_TALLY_PER_GRP;
  localparam int CTIP_OUT_W         = CTIP_GRP_MAX * CTIP_OUT_PER_GRP;
  localparam int CTIP_BANK_W        = (CTIP_TALLY_W + CTIP_OUT_W) / CTIP_BANK_SIZE;
  localparam int CTIP_PIN_W         = CTIP_IN_W + CTIP_GRP_MAX + 1;
  localparam int CTIP_IDX_W         = 5;
  localparam int CTIP_FUNC_W        = 8;

  localparam logic [9:0] CTIP_ADR_CTRL       = 10'h000;
  localparam logic [9:0] CTIP_ADR_STATUS     = 10'h004;
  localparam logic [9:0] CTIP_ADR_INPUT      = 10'h008;
  localparam logic [9:0] CTIP_ADR_EDGE_CLOSE = 10'h00c;
  localparam logic [9:0] CTIP_ADR_EDGE_OPEN  = 10'h010;
  localparam logic [9:0] CTIP_ADR_TALLY0     = 10'h014;
  localparam logic [9:0] CTIP_ADR_TALLY1     = 10'h018;
  localparam logic [9:0] CTIP_ADR_TALLY2     = 10'h01c;
  localparam logic [9:0] CTIP_ADR_CONTACT    = 10'h020;
  localparam logic [9:0] CTIP_ADR_IRQ_STAT   = 10'h024;
  localparam logic [9:0] CTIP_ADR_IRQ_MASK   = 10'h028;
  localparam logic [9:0] CTIP_ADR_FUNC_BASE  = 10'h200;

  localparam int CTIP_CTRL_EN_BIT    = 0;
  localparam int CTIP_CTRL_LARGE_BIT = 1;

  localparam logic [31:0] CTIP_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTIP_EDGE_RST = 32'h0000_0000;
  localparam logic [31:0] CTIP_WORD_RST = 32'h0000_0000;
  localparam logic [CTIP_PIN_W-1:0] CTIP_PIN_RST = {1'b0, 4'h0, 32'hffff_ffff};

  typedef struct packed {
    logic                   valid;
    logic                   closing;
    logic [CTIP_IDX_W-1:0]  src;
    logic [CTIP_FUNC_W-1:0] func;
  } ctip_trig_t;

endpackage

// ### ctip_port.sv
// Contact input and relay output port of a video switcher frame.
// Assumes contact pins, board-present pins and the field pulse are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module ctip_port
  import ctip_pkg::*;
#(
  parameter int GROUPS_FITTED = CTIP_GRP_MAX
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [31:0]             wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [CTIP_IN_W-1:0]    contact_input_n_i,
  input  wire logic [CTIP_GRP_MAX-1:0] mix_effect_stage_present_i,
  input  wire logic                    field_sync_i,
  output logic      [CTIP_TALLY_W-1:0] tally_o,
  output logic      [CTIP_OUT_W-1:0]   contact_output_o,
  output logic      [CTIP_BANK_W-1:0]  bank_return_busy_o,
  output ctip_trig_t                   trigger_o,
  output logic                         irq_o
);

  // Merges a bus write into a word under the byte enables.
  function automatic logic [31:0] merge_sel(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Finds the lowest set bit of a pending vector.
  function automatic logic [CTIP_IDX_W-1:0] lowest_idx(input logic [CTIP_IN_W-1:0] v);
    logic [CTIP_IDX_W-1:0] res;
    res = '0;
    for (int i = CTIP_IN_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        res = CTIP_IDX_W'(i);
      end
    end
    return res;
  endfunction

  logic [CTIP_PIN_W-1:0]   pin_s1_q;
  logic [CTIP_PIN_W-1:0]   pin_s2_q;
  logic [CTIP_PIN_W-1:0]   pin_s3_q;
  logic [CTIP_PIN_W-1:0]   pin_f_q;
  logic                    field_prev_q;
  logic                    field_tick;
  logic [31:0]             ctrl_q;
  logic [CTIP_IN_W-1:0]    edge_close_q;
  logic [CTIP_IN_W-1:0]    edge_open_q;
  logic [CTIP_TALLY_W-1:0] tally_q;
  logic [CTIP_OUT_W-1:0]   contact_q;
  logic [CTIP_IN_W-1:0]    irq_stat_q;
  logic [CTIP_IN_W-1:0]    irq_mask_q;
  logic [CTIP_GRP_MAX-1:0] grp_en_d;
  logic [CTIP_GRP_MAX-1:0] grp_en_q;
  logic [CTIP_IN_W-1:0]    in_en;
  logic [CTIP_TALLY_W-1:0] tally_en;
  logic [CTIP_OUT_W-1:0]   out_en;
  logic [CTIP_IN_W-1:0]    in_act;
  logic [CTIP_IN_W-1:0]    samp_q;
  logic [CTIP_IN_W-1:0]    new_close;
  logic [CTIP_IN_W-1:0]    new_open;
  logic [CTIP_IN_W-1:0]    new_trig;
  logic [CTIP_IN_W-1:0]    pend_q;
  logic [CTIP_IN_W-1:0]    pend_close_q;
  logic [CTIP_IDX_W-1:0]   pick_idx;
  logic [CTIP_IN_W-1:0]    pick_mask;
  logic                    sc_vld_q;
  logic                    sc_close_q;
  logic [CTIP_IDX_W-1:0]   sc_idx_q;
  logic [CTIP_FUNC_W-1:0]  func_bus;
  logic [CTIP_FUNC_W-1:0]  func_scan;
  logic                    req;
  logic                    pend_bus_q;
  logic                    bus_wr;
  logic                    bus_rd;
  logic                    adr_ok;
  logic                    adr_func;
  logic [9:0]              adr;
  logic [31:0]             rd_mux;
  logic [CTIP_TALLY_W-1:0] tally_d;
  logic [CTIP_OUT_W-1:0]   contact_d;

  assign adr      = wb_adr_i[9:0];
  assign adr_ok   = (wb_adr_i[31:10] == 22'h00_0000);
  assign adr_func = adr_ok && (adr[9:7] == CTIP_ADR_FUNC_BASE[9:7]);
  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !pend_bus_q;
  assign bus_wr   = pend_bus_q && wb_we_i;
  assign bus_rd   = pend_bus_q && !wb_we_i;

  // Pins pass three flops; a level is taken once the second and third agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= CTIP_PIN_RST;
      pin_s2_q <= CTIP_PIN_RST;
      pin_s3_q <= CTIP_PIN_RST;
      pin_f_q  <= CTIP_PIN_RST;
    end else begin
      pin_s1_q <= {field_sync_i, mix_effect_stage_present_i, contact_input_n_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      field_prev_q <= 1'b0;
    end else begin
      field_prev_q <= pin_f_q[CTIP_PIN_W-1];
    end
  end

  assign field_tick = pin_f_q[CTIP_PIN_W-1] && !field_prev_q;

  // Groups come alive only with their stage board and within the frame size.
  always_comb begin
    for (int g = 0; g < CTIP_GRP_MAX; g++) begin
      grp_en_d[g] = ctrl_q[CTIP_CTRL_EN_BIT]
                    && pin_f_q[CTIP_IN_W + g]
                    && (g < GROUPS_FITTED)
                    && ((g < CTIP_GRP_SMALL) || ctrl_q[CTIP_CTRL_LARGE_BIT]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grp_en_q <= '0;
    end else begin
      grp_en_q <= grp_en_d;
    end
  end

  // Channel k of every kind belongs to group k divided by the group size.
  always_comb begin
    for (int i = 0; i < CTIP_IN_W; i++) begin
      in_en[i] = grp_en_q[i / CTIP_IN_PER_GRP];
    end
    for (int i = 0; i < CTIP_TALLY_W; i++) begin
      tally_en[i] = grp_en_q[i / CTIP_TALLY_PER_GRP];
    end
    for (int i = 0; i < CTIP_OUT_W; i++) begin
      out_en[i] = grp_en_q[i / CTIP_OUT_PER_GRP];
    end
  end

  // A low pin means the contact is closed to its grounded return.
  assign in_act    = ~pin_f_q[CTIP_IN_W-1:0] & in_en;
  assign new_close = field_tick ? (in_act & ~samp_q & edge_close_q) : '0;
  assign new_open  = field_tick ? (~in_act & samp_q & edge_open_q & in_en) : '0;
  assign new_trig  = new_close | new_open;

  // Inputs are looked at once per field, so a closure must span a field edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_q <= '0;
    end else if (field_tick) begin
      samp_q <= in_act;
    end
  end

  // Triggers queue here and leave one per cycle, lowest channel first.
  assign pick_idx  = lowest_idx(pend_q);
  assign pick_mask = (|pend_q) ? (CTIP_IN_W'(1) << pick_idx) : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q       <= '0;
      pend_close_q <= '0;
    end else begin
      pend_q       <= (pend_q & ~pick_mask) | new_trig;
      pend_close_q <= (pend_close_q & ~new_trig) | new_close;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sc_vld_q   <= 1'b0;
      sc_close_q <= 1'b0;
      sc_idx_q   <= '0;
    end else begin
      sc_vld_q   <= |pend_q;
      sc_close_q <= pend_close_q[pick_idx];
      sc_idx_q   <= pick_idx;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trigger_o <= '0;
    end else begin
      trigger_o.valid   <= sc_vld_q;
      trigger_o.closing <= sc_close_q;
      trigger_o.src     <= sc_idx_q;
      trigger_o.func    <= func_scan;
    end
  end

  ctip_func_mem #(
    .DEPTH (CTIP_IN_W),
    .WIDTH (CTIP_FUNC_W),
    .AW    (CTIP_IDX_W)
  ) u_func_mem (
    .clk_i     (clk_i),
    .we_i      (bus_wr && adr_func && wb_sel_i[0]),
    .waddr_i   (adr[CTIP_IDX_W+1:2]),
    .wdata_i   (wb_dat_i[CTIP_FUNC_W-1:0]),
    .raddr_a_i (adr[CTIP_IDX_W+1:2]),
    .rdata_a_o (func_bus),
    .raddr_b_i (pick_idx),
    .rdata_b_o (func_scan)
  );

  // Control and configuration words written by software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q       <= CTIP_CTRL_RST;
      edge_close_q <= CTIP_EDGE_RST;
      edge_open_q  <= CTIP_EDGE_RST;
      irq_mask_q   <= CTIP_WORD_RST;
    end else if (bus_wr && adr_ok) begin
      case (adr)
        CTIP_ADR_CTRL: begin
          ctrl_q <= merge_sel(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0003;
        end
        CTIP_ADR_EDGE_CLOSE: begin
          edge_close_q <= merge_sel(edge_close_q, wb_dat_i, wb_sel_i);
        end
        CTIP_ADR_EDGE_OPEN: begin
          edge_open_q <= merge_sel(edge_open_q, wb_dat_i, wb_sel_i);
        end
        CTIP_ADR_IRQ_MASK: begin
          irq_mask_q <= merge_sel(irq_mask_q, wb_dat_i, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
  end

  // Relay states requested by software, one bit per relay line.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tally_q   <= '0;
      contact_q <= '0;
    end else if (bus_wr && adr_ok) begin
      case (adr)
        CTIP_ADR_TALLY0: begin
          tally_q[31:0] <= merge_sel(tally_q[31:0], wb_dat_i, wb_sel_i);
        end
        CTIP_ADR_TALLY1: begin
          tally_q[63:32] <= merge_sel(tally_q[63:32], wb_dat_i, wb_sel_i);
        end
        CTIP_ADR_TALLY2: begin
          tally_q[95:64] <= merge_sel(tally_q[95:64], wb_dat_i, wb_sel_i);
        end
        CTIP_ADR_CONTACT: begin
          contact_q <= merge_sel(contact_q, wb_dat_i, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
  end

  // Relays of an absent group stay open.
  assign tally_d   = tally_q & tally_en;
  assign contact_d = contact_q & out_en;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tally_o            <= '0;
      contact_output_o   <= '0;
      bank_return_busy_o <= '0;
    end else begin
      tally_o          <= tally_d;
      contact_output_o <= contact_d;
      for (int k = 0; k < CTIP_TALLY_W / CTIP_BANK_SIZE; k++) begin
        bank_return_busy_o[k] <= |tally_d[k*CTIP_BANK_SIZE +: CTIP_BANK_SIZE];
      end
      for (int k = 0; k < CTIP_OUT_W / CTIP_BANK_SIZE; k++) begin
        bank_return_busy_o[CTIP_TALLY_W / CTIP_BANK_SIZE + k] <=
          |contact_d[k*CTIP_BANK_SIZE +: CTIP_BANK_SIZE];
      end
    end
  end

  // Trigger events are sticky; a read clears them, but a new event wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else if (bus_rd && adr_ok && (adr == CTIP_ADR_IRQ_STAT)) begin
      irq_stat_q <= new_trig;
    end else begin
      irq_stat_q <= irq_stat_q | new_trig;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read data selection; unmapped words read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (adr_func) begin
      rd_mux = {24'h00_0000, func_bus};
    end else if (adr_ok) begin
      case (adr)
        CTIP_ADR_CTRL:       rd_mux = ctrl_q;
        CTIP_ADR_STATUS:     rd_mux = {24'h00_0000, grp_en_q, pin_f_q[CTIP_IN_W +: CTIP_GRP_MAX]};
        CTIP_ADR_INPUT:      rd_mux = samp_q;
        CTIP_ADR_EDGE_CLOSE: rd_mux = edge_close_q;
        CTIP_ADR_EDGE_OPEN:  rd_mux = edge_open_q;
        CTIP_ADR_TALLY0:     rd_mux = tally_q[31:0];
        CTIP_ADR_TALLY1:     rd_mux = tally_q[63:32];
        CTIP_ADR_TALLY2:     rd_mux = tally_q[95:64];
        CTIP_ADR_CONTACT:    rd_mux = contact_q;
        CTIP_ADR_IRQ_STAT:   rd_mux = irq_stat_q;
        CTIP_ADR_IRQ_MASK:   rd_mux = irq_mask_q;
        default:             rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Every access is answered two edges after it is first seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_bus_q <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
    end else begin
      pend_bus_q <= req;
      wb_ack_o   <= pend_bus_q;
      if (bus_rd) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// ### ctip_port_monitor.sv
// Checker of the contact input and tally port, watching top-level ports only.
// Assumes it is bound to the port by the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module ctip_port_monitor
  import ctip_pkg::*;
#(
  parameter int GROUPS_FITTED = CTIP_GRP_MAX
) (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [31:0]             wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic [CTIP_IN_W-1:0]    contact_input_n_i,
  input wire logic [CTIP_GRP_MAX-1:0] mix_effect_stage_present_i,
  input wire logic                    field_sync_i,
  input wire logic [CTIP_TALLY_W-1:0] tally_o,
  input wire logic [CTIP_OUT_W-1:0]   contact_output_o,
  input wire logic [CTIP_BANK_W-1:0]  bank_return_busy_o,
  input wire ctip_trig_t              trigger_o
);
  logic [CTIP_BANK_W-1:0] bank_exp;
  logic [7:0]             since_q;
  logic                   fs_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Expected bank return state from the relay drives.
  always_comb begin
    for (int k = 0; k < 24; k++) begin
      bank_exp[k] = |tally_o[4*k+:4];
    end
    for (int k = 0; k < 8; k++) begin
      bank_exp[24+k] = |contact_output_o[4*k+:4];
    end
  end

  // Cycles since the raw field pulse last rose.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_q    <= 1'b0;
      since_q <= 8'hff;
    end else begin
      fs_q <= field_sync_i;
      if (field_sync_i && !fs_q) begin
        since_q <= 8'h00;
      end else if (since_q != 8'hff) begin
        since_q <= since_q + 8'h01;
      end
    end
  end

  ack_timing_a: assert property (
    $rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o [*2] ##1 wb_ack_o)
    else $error("ack not two cycles after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  unmapped_read_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[31:10] != 22'h0 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  contact_write_a: assert property (
    wb_ack_o && wb_we_i && wb_sel_i == 4'hf && wb_adr_i == {22'h0, CTIP_ADR_CONTACT}
    |=> contact_output_o == $past(wb_dat_i))
    else $error("contact outputs differ from written word");
  tally_hold_a: assert property (
    !$stable(tally_o) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("tally changed without a write");
  bank_return_a: assert property (bank_return_busy_o == bank_exp)
    else $error("bank return busy wrong");
  trig_level_a: assert property (
    trigger_o.valid |-> contact_input_n_i[trigger_o.src] == !trigger_o.closing)
    else $error("trigger edge disagrees with pin");
  trig_present_a: assert property (
    trigger_o.valid |-> mix_effect_stage_present_i[trigger_o.src[4:3]])
    else $error("trigger from absent group");
  trig_fitted_a: assert property (
    trigger_o.valid |-> trigger_o.src[4:3] < GROUPS_FITTED)
    else $error("trigger from unfitted group");
  trig_field_a: assert property (
    trigger_o.valid |-> since_q inside {[8'd3:8'd60]})
    else $error("trigger not tied to a field boundary");
endmodule
`default_nettype wire

// ### tb_top.sv
// Testbench top: drives the port over Wishbone and closes contacts through the model.
// Assumes the checker and the contact model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ctip_pkg::*;
();
  logic                    clk_i;
  logic                    rst_i;
  logic                    cyc;
  logic                    stb;
  logic                    we;
  logic [31:0]             adr;
  logic [3:0]              sel;
  logic [31:0]             dat_w;
  logic [31:0]             dat_r;
  logic                    ack;
  logic [CTIP_IN_W-1:0]    pins_n;
  logic [CTIP_GRP_MAX-1:0] present;
  logic                    fsync;
  logic [CTIP_TALLY_W-1:0] tally;
  logic [CTIP_OUT_W-1:0]   couts;
  logic [CTIP_BANK_W-1:0]  busy;
  ctip_trig_t              trig;
  logic                    irq;
  logic [31:0]             closed;
  logic [31:0]             q;
  ctip_trig_t              t;
  ctip_trig_t              trig_log[$];
  int                      bad_count;
  int                      checks_done;

  ctip_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .contact_input_n_i(pins_n), .mix_effect_stage_present_i(present), .field_sync_i(fsync),
    .tally_o(tally), .contact_output_o(couts), .bank_return_busy_o(busy), .trigger_o(trig),
    .irq_o(irq));
  ctip_contacts u_contacts (.clk_i(clk_i), .rst_i(rst_i), .close_i(closed),
    .contact_input_n_o(pins_n), .field_sync_o(fsync));

  always #50 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (trig.valid === 1'b1) begin
      trig_log.push_back(trig);
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic stall(input string nm);
    $display("[FAIL] %s expected answer seen none", nm);
    bad_count++;
    give_verdict();
  endtask

  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    sel   <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) stall("bus ack");
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, {22'h0, a}, d, 4'hf, r);
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    wb(1'b0, {22'h0, a}, 32'h0, 4'hf, d);
  endtask

  task automatic next_trig(output ctip_trig_t x);
    int n;
    n = 0;
    while (trig_log.size() == 0 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (trig_log.size() == 0) stall("trigger");
    x = trig_log.pop_front();
  endtask

  task automatic chk_trig(input logic c, input logic [4:0] s, input logic [7:0] f);
    next_trig(t);
    chk("trigger", {17'h0, 1'b1, c, s, f}, {17'h0, t});
  endtask

  task automatic t_reset();
    rd(CTIP_ADR_CTRL, q);
    chk("ctrl reset", CTIP_CTRL_RST, q);
    rd(CTIP_ADR_EDGE_CLOSE, q);
    chk("edge reset", CTIP_EDGE_RST, q);
    chk("tally reset", 32'h0, tally[31:0]);
    wb(1'b1, 32'h0000_0400, 32'hffff_ffff, 4'hf, q);
    wb(1'b0, 32'h0000_0400, 32'h0, 4'hf, q);
    chk("unmapped", 32'h0, q);
  endtask

  task automatic t_relays();
    wr(CTIP_ADR_TALLY1, 32'h8000_0001);
    wr(CTIP_ADR_CONTACT, 32'h0000_0100);
    wb(1'b1, {22'h0, CTIP_ADR_TALLY0}, 32'hffff_ffff, 4'h1, q);
    @(negedge clk_i);
    chk("tally low", 32'h0000_00ff, tally[31:0]);
    chk("tally mid", 32'h8000_0001, tally[63:32]);
    chk("contacts", 32'h0000_0100, couts);
    chk("banks", 32'h0400_8103, busy);
    wr(CTIP_ADR_TALLY0, 32'h0);
    wr(CTIP_ADR_TALLY1, 32'h0);
    wr(CTIP_ADR_CONTACT, 32'h0);
  endtask

  task automatic t_trig();
    wr(CTIP_ADR_FUNC_BASE, 32'h11);
    wr(CTIP_ADR_FUNC_BASE + 10'h020, 32'h5a);
    wr(CTIP_ADR_EDGE_CLOSE, 32'h0000_0101);
    wr(CTIP_ADR_EDGE_OPEN, 32'h0000_0100);
    wr(CTIP_ADR_IRQ_MASK, 32'h0000_0100);
    rd(CTIP_ADR_EDGE_OPEN, q);
    chk("edge open", 32'h0000_0100, q);
    rd(CTIP_ADR_IRQ_MASK, q);
    chk("irq mask", 32'h0000_0100, q);
    rd(CTIP_ADR_FUNC_BASE + 10'h020, q);
    chk("function word", 32'h0000_005a, q);
    closed <= 32'h0000_0101;
    chk_trig(1'b1, 5'd0, 8'h11);
    chk_trig(1'b1, 5'd8, 8'h5a);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(CTIP_ADR_IRQ_STAT, q);
    chk("irq status", 32'h0000_0101, q);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(CTIP_ADR_INPUT, q);
    chk("input state", 32'h0000_0101, q);
    closed <= 32'h0;
    chk_trig(1'b0, 5'd8, 8'h5a);
    repeat (128) @(posedge clk_i);
    chk("extra triggers", 32'h0, 32'(trig_log.size()));
  endtask

  task automatic t_gate();
    wr(CTIP_ADR_FUNC_BASE + 10'h060, 32'h33);
    present <= 4'hb;
    wr(CTIP_ADR_CTRL, 32'h1);
    wr(CTIP_ADR_EDGE_CLOSE, 32'h0101_0000);
    closed <= 32'h0101_0000;
    repeat (192) @(posedge clk_i);
    chk("gated triggers", 32'h0, 32'(trig_log.size()));
    rd(CTIP_ADR_STATUS, q);
    chk("status small", 32'h0000_003b, q);
    rd(CTIP_ADR_FUNC_BASE + 10'h060, q);
    chk("function late", 32'h0000_0033, q);
    wr(CTIP_ADR_TALLY2, 32'hffff_ffff);
    @(negedge clk_i);
    chk("tally gated", 32'h0, tally[95:64]);
    chk("banks gated", 32'h0, busy);
    rd(CTIP_ADR_TALLY2, q);
    chk("tally top word", 32'hffff_ffff, q);
    wr(CTIP_ADR_TALLY2, 32'h0);
    wr(CTIP_ADR_CTRL, 32'h3);
    chk_trig(1'b1, 5'd24, 8'h33);
    rd(CTIP_ADR_STATUS, q);
    chk("status large", 32'h0000_00bb, q);
  endtask

  initial begin
    clk_i       = 1'b0;
    rst_i       = 1'b1;
    cyc         = 1'b0;
    stb         = 1'b0;
    we          = 1'b0;
    adr         = 32'h0;
    sel         = 4'h0;
    dat_w       = 32'h0;
    present     = 4'hf;
    closed      = 32'h0;
    bad_count   = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    wr(CTIP_ADR_CTRL, 32'h3);
    t_relays();
    t_trig();
    t_gate();
    give_verdict();
  end
endmodule

bind ctip_port ctip_port_monitor #(.GROUPS_FITTED(GROUPS_FITTED)) u_mon (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .contact_input_n_i(contact_input_n_i),
  .mix_effect_stage_present_i(mix_effect_stage_present_i), .field_sync_i(field_sync_i),
  .tally_o(tally_o), .contact_output_o(contact_output_o),
  .bank_return_busy_o(bank_return_busy_o), .trigger_o(trigger_o));
`default_nettype wire
